// ===== hdl/ccb_regs.svh
// named constants for the condition and branch execution block
`ifndef CCB_REGS_SVH
`define CCB_REGS_SVH

// field widths
`define CCB_CC_W         4
`define CCB_IMM_W        5
`define CCB_DISP_W       9
`define CCB_BYTE_W       8

// condition codes
`define CCB_CC_WRAP      4'h0
`define CCB_CC_CARRY     4'h1
`define CCB_CC_NULL      4'h2
`define CCB_CC_NOT_HIGH  4'h3
`define CCB_CC_NEG       4'h4
`define CCB_CC_ALWAYS    4'h5
`define CCB_CC_LT        4'h6
`define CCB_CC_LE        4'h7
`define CCB_CC_NO_WRAP   4'h8
`define CCB_CC_NO_CARRY  4'h9
`define CCB_CC_NOT_NULL  4'ha
`define CCB_CC_HIGH      4'hb
`define CCB_CC_POS       4'hc
`define CCB_CC_CLAMP     4'hd
`define CCB_CC_GE        4'he
`define CCB_CC_GT        4'hf

// cycle counts (issue, repeat and latency alike)
`define CCB_CYC_BR_TAKEN 4'h2
`define CCB_CYC_BR_FAIL  4'h1
`define CCB_CYC_CONDITIONAL_MOVE     4'h1
`define CCB_CYC_SWAP     4'h1
`define CCB_CYC_RET      4'h3
`define CCB_CYC_ONE      4'h1

// program counter steps and reset values
`define CCB_PC_STEP_S    32'h2
`define CCB_PC_STEP_L    32'h4
`define CCB_PC_RESET     32'h0
`define CCB_FLAGS_RESET  5'h0

`endif

// ===== hdl/ccb_pkg.sv
// types shared by the condition and branch execution block
package ccb_pkg;

  // five status flags
  typedef struct packed {
    logic clamp;
    logic carry;
    logic signed_wrap;
    logic negative;
    logic null_result;
  } ccb_flags_t;

  // operations handled here
  typedef enum logic [2:0] {
    CCB_OP_ALU      = 3'h0,
    CCB_OP_BRANCH   = 3'h1,
    CCB_OP_CONDITIONAL_MOVE_REG = 3'h2,
    CCB_OP_CONDITIONAL_MOVE_IMM = 3'h3,
    CCB_OP_BSH      = 3'h4,
    CCB_OP_BSW      = 3'h5,
    CCB_OP_TC_RET   = 3'h6,
    CCB_OP_DBG_RET  = 3'h7
  } ccb_op_t;

  // per-flag update mode
  typedef enum logic [1:0] {
    CCB_FM_KEEP   = 2'h0,
    CCB_FM_CLEAR  = 2'h1,
    CCB_FM_RESULT = 2'h2
  } ccb_fmode_t;

  typedef struct packed {
    ccb_fmode_t clamp;
    ccb_fmode_t carry;
    ccb_fmode_t signed_wrap;
    ccb_fmode_t negative;
    ccb_fmode_t null_result;
  } ccb_fmodes_t;

  // sequencer states, one-hot
  typedef enum logic [1:0] {
    CCB_ST_IDLE = 2'h1,
    CCB_ST_WAIT = 2'h2
  } ccb_state_t;

endpackage : ccb_pkg

// ===== hdl/ccb_cond_if.sv
// condition code lookup carrier between sequencer and evaluator
`timescale 1ns/1ps
`include "ccb_regs.svh"
interface ccb_cond_if;
  import ccb_pkg::*;
  logic [`CCB_CC_W-1:0] code;
  ccb_flags_t           flags;
  logic                 hold;
  modport eval (input code, input flags, output hold);
  modport user (output code, output flags, input hold);
endinterface : ccb_cond_if

// ===== hdl/ccb_cond_eval.sv
// combinational condition code evaluator
`timescale 1ns/1ps
`include "ccb_regs.svh"
module ccb_cond_eval (
  // condition lookup
  ccb_cond_if.eval cif
);
  import ccb_pkg::*;

  logic lt_s;

  // signed less-than term
  assign lt_s = cif.flags.negative ^ cif.flags.signed_wrap;

  // no state: decision follows current flags
  always_comb begin // RULE_13
    case (cif.code)
      `CCB_CC_WRAP:     cif.hold = cif.flags.signed_wrap; // RULE_05
      `CCB_CC_NO_WRAP:  cif.hold = !cif.flags.signed_wrap; // RULE_05
      `CCB_CC_CARRY:    cif.hold = cif.flags.carry; // RULE_01
      `CCB_CC_NO_CARRY: cif.hold = !cif.flags.carry; // RULE_01
      `CCB_CC_NULL:     cif.hold = cif.flags.null_result; // RULE_05
      `CCB_CC_NOT_NULL: cif.hold = !cif.flags.null_result; // RULE_05
      `CCB_CC_NOT_HIGH:
        cif.hold = cif.flags.carry | cif.flags.null_result; // RULE_02
      `CCB_CC_HIGH:
        cif.hold = !(cif.flags.carry | cif.flags.null_result); // RULE_02
      `CCB_CC_NEG:      cif.hold = cif.flags.negative; // RULE_05
      `CCB_CC_POS:      cif.hold = !cif.flags.negative; // RULE_05
      `CCB_CC_ALWAYS:   cif.hold = 1'b1; // RULE_05
      `CCB_CC_CLAMP:    cif.hold = cif.flags.clamp; // RULE_05
      `CCB_CC_LT:       cif.hold = lt_s; // RULE_03
      `CCB_CC_GE:       cif.hold = !lt_s; // RULE_03
      `CCB_CC_LE:
        cif.hold = lt_s | cif.flags.null_result; // RULE_04
      `CCB_CC_GT:
        cif.hold = !(lt_s | cif.flags.null_result); // RULE_04
      default:          cif.hold = 1'b0;
    endcase
  end

endmodule : ccb_cond_eval

// ===== hdl/ccb_exec.sv
// condition, branch, move, byte swap and status restore execution
//
// Functional notes
// [RULE_01] code 0001 carry set, 1001 carry clear
// [RULE_02] 0011 carry or null; 1011 both clear
// [RULE_03] 0110 negative xor wrap; 1110 its inverse
// [RULE_04] 0111 adds null to that; 1111 inverse
// [RULE_05] other codes: wrap, null, negative, always, clamp
// [RULE_06] flags kept, cleared or taken from result
// [RULE_07] both returns restore flags from saved copy
// [RULE_08] issue, repeat and latency counts are honoured
// [RULE_09] taken branch adds displacement, two cycles
// [RULE_10] conditional move picks second or first source
// [RULE_11] halfword swap, wrap cleared, others updated; the code keeps clamp unchanged
// [RULE_12] word reverse, wrap cleared, others updated; the code keeps clamp unchanged
// [RULE_13] condition evaluation is combinational on flags
`timescale 1ns/1ps
`include "ccb_regs.svh"
module ccb_exec #(
  parameter int DW = 32,
  parameter int CW = 4
) (
  // clock and reset
  input  wire logic                 CLK_SYS_I,
  input  wire logic                 SRST_I,
  // instruction request
  input  wire logic                 OP_VALID_I,
  input  wire ccb_pkg::ccb_op_t     OP_KIND_I,
  input  wire logic [`CCB_CC_W-1:0] OP_COND_I,
  input  wire logic [DW-1:0]        OP_SRC1_I,
  input  wire logic [DW-1:0]        OP_SRC2_I,
  input  wire logic [`CCB_IMM_W-1:0] OP_IMM5_I,
  input  wire logic [`CCB_DISP_W-1:0] OP_DISP9_I,
  input  wire logic                 OP_WIDE_I,
  // generic flag update
  input  wire ccb_pkg::ccb_flags_t  ALU_FLAGS_I,
  input  wire ccb_pkg::ccb_fmodes_t ALU_MODES_I,
  input  wire logic [CW-1:0]        ALU_ISSUE_I,
  input  wire logic [CW-1:0]        ALU_REPEAT_I,
  input  wire logic [CW-1:0]        ALU_LAT_I,
  // saved copies for returns
  input  wire ccb_pkg::ccb_flags_t  TC_STATUS_I,
  input  wire logic [DW-1:0]        TC_PC_I,
  input  wire ccb_pkg::ccb_flags_t  DBG_STATUS_I,
  input  wire logic [DW-1:0]        DBG_PC_I,
  // answers
  output logic                      OP_READY_O,
  output logic                      COND_TRUE_O,
  output logic                      RES_VALID_O,
  output logic [DW-1:0]             RES_DATA_O,
  output logic [DW-1:0]             PC_O,
  output ccb_pkg::ccb_flags_t       FLAGS_O
);
  import ccb_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [DW-1:0] sext_imm(
    input logic [`CCB_IMM_W-1:0] v);
    sext_imm = DW'($signed(v));
  endfunction : sext_imm

  function automatic logic [DW-1:0] sext_disp(
    input logic [`CCB_DISP_W-1:0] v);
    sext_disp = DW'($signed(v));
  endfunction : sext_disp

  // byte lane permutation: xor with 1 swaps pairs, with top reverses
  function automatic logic [DW-1:0] lane_perm(
    input logic [DW-1:0] w, input int sel);
    lane_perm = '0;
    for (int i = 0; i < DW / `CCB_BYTE_W; i++) begin
      lane_perm[i*`CCB_BYTE_W +: `CCB_BYTE_W] =
        w[(i ^ sel)*`CCB_BYTE_W +: `CCB_BYTE_W];
    end
  endfunction : lane_perm

  // carry of swaps: some lane of given byte count is zero
  function automatic logic lane_zero(
    input logic [DW-1:0] w, input int lb);
    lane_zero = 1'b0;
    for (int i = 0; i < DW / (lb * `CCB_BYTE_W); i++) begin
      if (((w >> (i*lb*`CCB_BYTE_W)) &
           ((DW'(1) << (lb*`CCB_BYTE_W)) - DW'(1))) == '0) begin
        lane_zero = 1'b1;
      end
    end
  endfunction : lane_zero

  function automatic logic apply_mode(
    input ccb_fmode_t m, input logic prev, input logic res);
    case (m)
      CCB_FM_CLEAR:  apply_mode = 1'b0;
      CCB_FM_RESULT: apply_mode = res;
      default:       apply_mode = prev;
    endcase
  endfunction : apply_mode

  function automatic logic [CW-1:0] at_least_one(
    input logic [CW-1:0] c);
    at_least_one = (c == '0) ? CW'(`CCB_CYC_ONE) : c;
  endfunction : at_least_one

  ////////////////////////////////////////////////////////////////////
  // declarations

  ccb_cond_if cif ();

  ccb_state_t     state;
  ccb_state_t     next_state;
  logic [CW-1:0]  wait_cnt;
  logic [CW-1:0]  blk_cnt;
  logic [CW-1:0]  next_blk;
  ccb_op_t        last_kind;
  logic           seen;
  logic           accept;
  logic           commit;
  logic           cond_hold;
  logic [DW-1:0]  fr_data;
  logic           fr_wr;
  ccb_flags_t     fr_flags;
  logic [DW-1:0]  fr_pc;
  logic [CW-1:0]  fr_lat;
  logic [CW-1:0]  fr_issue;
  logic [CW-1:0]  fr_repeat;
  logic [DW-1:0]  st_data;
  logic           st_wr;
  ccb_flags_t     st_flags;
  logic [DW-1:0]  st_pc;
  logic [DW-1:0]  cm_data;
  logic           cm_wr;
  ccb_flags_t     cm_flags;
  logic [DW-1:0]  cm_pc;

  ////////////////////////////////////////////////////////////////////
  // condition evaluation on the live flags

  assign cif.code  = OP_COND_I;
  assign cif.flags = FLAGS_O; // RULE_13
  assign cond_hold = cif.hold;

  ccb_cond_eval u_cond (
    .cif (cif.eval)
  );

  // request handshake
  assign accept = OP_VALID_I && OP_READY_O;

  ////////////////////////////////////////////////////////////////////
  // result of the presented instruction

  always_comb begin
    fr_data   = OP_SRC1_I;
    fr_wr     = 1'b0;
    fr_flags  = FLAGS_O;
    fr_pc     = PC_O + DW'(`CCB_PC_STEP_L);
    fr_lat    = CW'(`CCB_CYC_ONE);
    fr_issue  = CW'(`CCB_CYC_ONE);
    fr_repeat = CW'(`CCB_CYC_ONE);
    case (OP_KIND_I)
      CCB_OP_BRANCH: begin
        if (cond_hold) begin
          fr_pc  = PC_O + sext_disp(OP_DISP9_I); // RULE_09
          fr_lat = CW'(`CCB_CYC_BR_TAKEN); // RULE_09
        end else begin
          fr_pc  = PC_O + DW'(`CCB_PC_STEP_S);
          fr_lat = CW'(`CCB_CYC_BR_FAIL); // RULE_09
        end
        fr_issue  = fr_lat;
        fr_repeat = fr_lat;
      end
      CCB_OP_CONDITIONAL_MOVE_REG, CCB_OP_CONDITIONAL_MOVE_IMM: begin
        fr_wr = 1'b1;
        if (cond_hold) begin // RULE_10
          fr_data = (OP_KIND_I == CCB_OP_CONDITIONAL_MOVE_IMM) ?
                    sext_imm(OP_IMM5_I) : OP_SRC2_I;
        end
        fr_lat    = CW'(`CCB_CYC_CONDITIONAL_MOVE);
        fr_issue  = fr_lat;
        fr_repeat = fr_lat;
      end
      CCB_OP_BSH, CCB_OP_BSW: begin
        fr_wr = 1'b1;
        if (OP_KIND_I == CCB_OP_BSH) begin
          fr_data = lane_perm(OP_SRC1_I, 1); // RULE_11
          fr_flags.carry = lane_zero(fr_data, 2); // RULE_11
        end else begin
          fr_data = lane_perm(OP_SRC1_I,
                              DW / `CCB_BYTE_W - 1); // RULE_12
          fr_flags.carry = lane_zero(fr_data, 1); // RULE_12
        end
        fr_flags.signed_wrap = 1'b0; // RULE_11 RULE_12
        fr_flags.negative    = fr_data[DW-1];
        fr_flags.null_result = (fr_data == '0);
        fr_lat    = CW'(`CCB_CYC_SWAP);
        fr_issue  = fr_lat;
        fr_repeat = fr_lat;
      end
      CCB_OP_TC_RET, CCB_OP_DBG_RET: begin
        fr_flags  = (OP_KIND_I == CCB_OP_TC_RET) ?
                    TC_STATUS_I : DBG_STATUS_I; // RULE_07
        fr_pc     = (OP_KIND_I == CCB_OP_TC_RET) ? TC_PC_I : DBG_PC_I;
        fr_lat    = CW'(`CCB_CYC_RET);
        fr_issue  = fr_lat;
        fr_repeat = fr_lat;
      end
      default: begin
        // generic flag update with per-flag mode
        fr_flags.clamp = apply_mode(ALU_MODES_I.clamp, FLAGS_O.clamp,
                                    ALU_FLAGS_I.clamp); // RULE_06
        fr_flags.carry = apply_mode(ALU_MODES_I.carry, FLAGS_O.carry,
                                    ALU_FLAGS_I.carry); // RULE_06
        fr_flags.signed_wrap = apply_mode(ALU_MODES_I.signed_wrap,
          FLAGS_O.signed_wrap, ALU_FLAGS_I.signed_wrap); // RULE_06
        fr_flags.negative = apply_mode(ALU_MODES_I.negative,
          FLAGS_O.negative, ALU_FLAGS_I.negative); // RULE_06
        fr_flags.null_result = apply_mode(ALU_MODES_I.null_result,
          FLAGS_O.null_result, ALU_FLAGS_I.null_result); // RULE_06
        fr_pc = PC_O + (OP_WIDE_I ? DW'(`CCB_PC_STEP_L)
                                  : DW'(`CCB_PC_STEP_S));
        fr_lat    = at_least_one(ALU_LAT_I);
        fr_issue  = at_least_one(ALU_ISSUE_I);
        fr_repeat = at_least_one(ALU_REPEAT_I);
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // latency sequencer

  assign commit = (accept && fr_lat == CW'(`CCB_CYC_ONE)) ||
                  (state == CCB_ST_WAIT &&
                   wait_cnt == CW'(`CCB_CYC_ONE)); // RULE_08

  // committed values: fresh when immediate, else staged
  assign cm_data  = (state == CCB_ST_IDLE) ? fr_data  : st_data;
  assign cm_wr    = (state == CCB_ST_IDLE) ? fr_wr    : st_wr;
  assign cm_flags = (state == CCB_ST_IDLE) ? fr_flags : st_flags;
  assign cm_pc    = (state == CCB_ST_IDLE) ? fr_pc    : st_pc;

  // next state
  always_comb begin
    case (state)
      CCB_ST_IDLE:
        next_state = (accept && fr_lat != CW'(`CCB_CYC_ONE)) ?
                     CCB_ST_WAIT : CCB_ST_IDLE;
      CCB_ST_WAIT:
        next_state = commit ? CCB_ST_IDLE : CCB_ST_WAIT;
      default:
        next_state = CCB_ST_IDLE;
    endcase
  end

  // state and latency counter
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      state    <= CCB_ST_IDLE;
      wait_cnt <= '0;
    end else begin
      state <= next_state;
      if (accept) begin
        wait_cnt <= fr_lat - CW'(`CCB_CYC_ONE);
      end else if (wait_cnt != '0) begin
        wait_cnt <= wait_cnt - CW'(`CCB_CYC_ONE);
      end
    end
  end

  // issue or repeat spacing
  always_comb begin
    if (accept) begin
      next_blk = ((seen && OP_KIND_I == last_kind) ? fr_repeat
                  : fr_issue) - CW'(`CCB_CYC_ONE); // RULE_08
    end else if (blk_cnt != '0) begin
      next_blk = blk_cnt - CW'(`CCB_CYC_ONE);
    end else begin
      next_blk = '0;
    end
  end

  // ready and last instruction tracking
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      blk_cnt     <= '0;
      OP_READY_O  <= 1'b0;
      last_kind   <= CCB_OP_ALU;
      seen        <= 1'b0;
      COND_TRUE_O <= 1'b0;
    end else begin
      blk_cnt    <= next_blk;
      OP_READY_O <= (next_blk == '0) &&
                    (next_state == CCB_ST_IDLE); // RULE_08
      if (accept) begin
        last_kind   <= OP_KIND_I;
        seen        <= 1'b1;
        COND_TRUE_O <= cond_hold;
      end
    end
  end

  // staging for multi-cycle latency
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      st_data  <= '0;
      st_wr    <= 1'b0;
      st_flags <= `CCB_FLAGS_RESET;
      st_pc    <= `CCB_PC_RESET;
    end else if (accept) begin
      st_data  <= fr_data;
      st_wr    <= fr_wr;
      st_flags <= fr_flags;
      st_pc    <= fr_pc;
    end
  end

  // architectural flags and program counter
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      FLAGS_O <= `CCB_FLAGS_RESET;
      PC_O    <= `CCB_PC_RESET;
    end else if (commit) begin
      FLAGS_O <= cm_flags; // RULE_06 RULE_07
      PC_O    <= cm_pc; // RULE_09
    end
  end

  // register file write port
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      RES_VALID_O <= 1'b0;
      RES_DATA_O  <= '0;
    end else begin
      RES_VALID_O <= commit && cm_wr;
      if (commit && cm_wr) begin
        RES_DATA_O <= cm_data; // RULE_10
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);

  sequence take_s(ccb_op_t k);
    accept && OP_KIND_I == k;
  endsequence

  cc_lower_a: assert property ( // RULE_01
    ((OP_COND_I == `CCB_CC_CARRY) |-> cond_hold == FLAGS_O.carry) and
    ((OP_COND_I == `CCB_CC_NO_CARRY) |-> cond_hold != FLAGS_O.carry))
    else $error("carry condition wrong");
  cc_higher_a: assert property ( // RULE_02
    (OP_COND_I == `CCB_CC_HIGH) |->
    cond_hold == !(FLAGS_O.carry || FLAGS_O.null_result))
    else $error("higher condition wrong");
  cc_signed_a: assert property ( // RULE_03
    (OP_COND_I == `CCB_CC_LT) |->
    cond_hold == (FLAGS_O.negative ^ FLAGS_O.signed_wrap))
    else $error("signed less condition wrong");
  cc_signed_le_a: assert property ( // RULE_04
    (OP_COND_I == `CCB_CC_GT) |-> cond_hold ==
    !((FLAGS_O.negative ^ FLAGS_O.signed_wrap) || FLAGS_O.null_result))
    else $error("signed greater condition wrong");
  cc_other_a: assert property ( // RULE_05
    ((OP_COND_I == `CCB_CC_ALWAYS) |-> cond_hold) and
    ((OP_COND_I == `CCB_CC_CLAMP) |-> cond_hold == FLAGS_O.clamp))
    else $error("simple condition wrong");
  flag_keep_a: assert property ( // RULE_06
    (take_s(CCB_OP_ALU) ##0 (ALU_LAT_I == CW'(`CCB_CYC_ONE) &&
     ALU_MODES_I.carry == CCB_FM_KEEP &&
     ALU_MODES_I.signed_wrap == CCB_FM_CLEAR)) |=>
    FLAGS_O.carry == $past(FLAGS_O.carry) && !FLAGS_O.signed_wrap)
    else $error("flag mode not applied");
  ret_restore_a: assert property ( // RULE_07
    take_s(CCB_OP_TC_RET) |->
    ##3 FLAGS_O == $past(TC_STATUS_I, 3) && PC_O == $past(TC_PC_I, 3))
    else $error("return did not restore status");
  ret_spacing_a: assert property ( // RULE_08
    take_s(CCB_OP_DBG_RET) |=> !OP_READY_O [*2] ##1 OP_READY_O)
    else $error("return spacing wrong");
  br_taken_a: assert property ( // RULE_09
    (take_s(CCB_OP_BRANCH) ##0 cond_hold) |-> ##2
    PC_O == $past(PC_O, 2) + sext_disp($past(OP_DISP9_I, 2)) &&
    FLAGS_O == $past(FLAGS_O, 2))
    else $error("taken branch wrong");
  br_fail_a: assert property ( // RULE_09
    (take_s(CCB_OP_BRANCH) ##0 !cond_hold) |=>
    PC_O == $past(PC_O) + DW'(`CCB_PC_STEP_S) && OP_READY_O)
    else $error("failed branch wrong");
  conditional_move_pick_a: assert property ( // RULE_10
    take_s(CCB_OP_CONDITIONAL_MOVE_REG) |=> RES_VALID_O && RES_DATA_O ==
    ($past(cond_hold) ? $past(OP_SRC2_I) : $past(OP_SRC1_I)))
    else $error("conditional move result wrong");
  swap_half_a: assert property ( // RULE_11
    take_s(CCB_OP_BSH) |=> RES_DATA_O == {$past(OP_SRC1_I[23:16]),
    $past(OP_SRC1_I[31:24]), $past(OP_SRC1_I[7:0]),
    $past(OP_SRC1_I[15:8])} && !FLAGS_O.signed_wrap)
    else $error("halfword swap wrong");
  swap_word_a: assert property ( // RULE_12
    take_s(CCB_OP_BSW) |=> RES_DATA_O == {$past(OP_SRC1_I[7:0]),
    $past(OP_SRC1_I[15:8]), $past(OP_SRC1_I[23:16]),
    $past(OP_SRC1_I[31:24])} && FLAGS_O.null_result ==
    ($past(OP_SRC1_I) == '0))
    else $error("word reverse wrong");
  cc_live_a: assert property ( // RULE_13
    (take_s(CCB_OP_BSW) ##1 (accept && OP_COND_I == `CCB_CC_NULL)) |->
    cond_hold == ($past(OP_SRC1_I) == '0) ##1
    COND_TRUE_O == $past(cond_hold))
    else $error("condition not on live flags");

endmodule : ccb_exec

// ===== verification/cpu_condition_and_branch_exec_tb.sv
// self-checking bench for the condition and branch execution block
`timescale 1ns/1ps
`include "ccb_regs.svh"
module cpu_condition_and_branch_exec_tb;
  import ccb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // stimulus signals, all given values at time zero, then the outputs of the block
  logic         clk = 1'b0;
  logic         srst = 1'b1;
  logic         vld = 1'b0;
  ccb_op_t      kind = CCB_OP_ALU;
  logic [3:0]   cc = 4'h0;
  logic [31:0]  s1 = 32'h0;
  logic [31:0]  s2 = 32'h0;
  logic [4:0]   imm = 5'h0;
  logic [8:0]   disp = 9'h0;
  logic         wide = 1'b0;
  ccb_flags_t   afl = 5'h0;
  ccb_fmodes_t  amd = 10'h0;
  logic [3:0]   iss = 4'h1;
  logic [3:0]   rep = 4'h1;
  logic [3:0]   lat = 4'h1;
  ccb_flags_t   tcs = 5'h0;
  logic [31:0]  tcp = 32'h0;
  ccb_flags_t   dbs = 5'h0;
  logic [31:0]  dbp = 32'h0;
  logic         rdy;
  logic         ctrue;
  logic         rvld;
  logic [31:0]  rdat;
  logic [31:0]  pc;
  ccb_flags_t   fl;
  // bench model state
  logic [31:0]  exp_q[$];
  logic [31:0]  pc_m = 32'h0;
  ccb_flags_t   fl_m = 5'h0;
  ccb_op_t      prev_k = CCB_OP_ALU;
  logic         prev_v = 1'b0;
  int           fail_count = 0;
  int           checks_done = 0;
  int           seed = 32'hc1ede54d;

  always #10 clk = ~clk;

  ccb_exec dut_u (
    .CLK_SYS_I(clk), .SRST_I(srst), .OP_VALID_I(vld), .OP_KIND_I(kind),
    .OP_COND_I(cc), .OP_SRC1_I(s1), .OP_SRC2_I(s2), .OP_IMM5_I(imm),
    .OP_DISP9_I(disp), .OP_WIDE_I(wide), .ALU_FLAGS_I(afl),
    .ALU_MODES_I(amd), .ALU_ISSUE_I(iss), .ALU_REPEAT_I(rep),
    .ALU_LAT_I(lat), .TC_STATUS_I(tcs), .TC_PC_I(tcp),
    .DBG_STATUS_I(dbs), .DBG_PC_I(dbp), .OP_READY_O(rdy),
    .COND_TRUE_O(ctrue), .RES_VALID_O(rvld), .RES_DATA_O(rdat),
    .PC_O(pc), .FLAGS_O(fl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // comparison and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // expected condition outcome from the flags
  function automatic logic cond_f(input logic [3:0] c, input ccb_flags_t f);
    logic b;
    case (c[2:0])
      3'h0: b = f.signed_wrap;
      3'h1: b = f.carry;
      3'h2: b = f.null_result;
      3'h3: b = f.carry | f.null_result;
      3'h4: b = f.negative;
      3'h5: b = c[3] ? ~f.clamp : 1'b1;
      3'h6: b = f.negative ^ f.signed_wrap;
      default: b = (f.negative ^ f.signed_wrap) | f.null_result;
    endcase
    return b ^ c[3];
  endfunction : cond_f

  function automatic logic fupd(input logic [1:0] m, input logic p,
                                input logic r);
    return (m == 2'h1) ? 1'b0 : (m == 2'h2) ? r : p;
  endfunction : fupd

  function automatic ccb_flags_t swp_f(input logic [31:0] v, input logic h);
    ccb_flags_t f;
    f.clamp = fl_m.clamp;
    f.signed_wrap = 1'b0;
    f.negative = v[31];
    f.null_result = (v == 32'h0);
    f.carry = h ? (v[31:16] == 16'h0 || v[15:0] == 16'h0)
                : (v[31:24] == 8'h0 || v[23:16] == 8'h0 ||
                   v[15:8] == 8'h0 || v[7:0] == 8'h0);
    return f;
  endfunction : swp_f

  ////////////////////////////////////////////////////////////////////////////
  // one request: model, handshake, then check committed state
  task automatic go();
    logic       c;
    logic [31:0] v;
    int         l;
    int         b;
    int         lo;
    int         n;
    c = cond_f(cc, fl_m);
    l = 1;
    case (kind)
      CCB_OP_ALU: begin
        l = (lat == 0) ? 1 : lat;
        pc_m = pc_m + (wide ? 32'h4 : 32'h2);
        fl_m = {fupd(amd[9:8], fl_m[4], afl[4]),
                fupd(amd[7:6], fl_m[3], afl[3]),
                fupd(amd[5:4], fl_m[2], afl[2]),
                fupd(amd[3:2], fl_m[1], afl[1]),
                fupd(amd[1:0], fl_m[0], afl[0])};
      end
      CCB_OP_BRANCH: begin
        l = c ? 2 : 1;
        pc_m = c ? pc_m + {{23{disp[8]}}, disp} : pc_m + 32'h2;
      end
      CCB_OP_CONDITIONAL_MOVE_REG, CCB_OP_CONDITIONAL_MOVE_IMM: begin
        v = (kind == CCB_OP_CONDITIONAL_MOVE_IMM) ? {{27{imm[4]}}, imm} : s2;
        exp_q.push_back(c ? v : s1);
        pc_m = pc_m + 32'h4;
      end
      CCB_OP_BSH, CCB_OP_BSW: begin
        v = (kind == CCB_OP_BSH) ?
            {s1[23:16], s1[31:24], s1[7:0], s1[15:8]} :
            {s1[7:0], s1[15:8], s1[23:16], s1[31:24]};
        exp_q.push_back(v);
        fl_m = swp_f(v, kind == CCB_OP_BSH);
        pc_m = pc_m + 32'h4;
      end
      default: begin
        l = 3;
        pc_m = (kind == CCB_OP_TC_RET) ? tcp : dbp;
        fl_m = (kind == CCB_OP_TC_RET) ? tcs : dbs;
      end
    endcase
    b = l;
    if (kind == CCB_OP_ALU) begin
      b = (prev_v && prev_k == CCB_OP_ALU) ? rep : iss;
      b = (b == 0) ? 1 : b;
    end
    b = (b > l) ? b : l;
    vld = 1'b1;
    n = 0;
    while (rdy !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 50) begin
        fail_count++;
        wrap_up();
      end
    end
    @(posedge clk);
    #1;
    // valid stays up; the next call reloads fields before an edge
    prev_k = kind;
    prev_v = 1'b1;
    lo = 0;
    while (rdy !== 1'b1) begin
      @(posedge clk);
      #1;
      lo++;
      if (lo > 50) begin
        fail_count++;
        wrap_up();
      end
    end
    chk(lo, b - 1);
    chk(ctrue, c);
    chk(pc, pc_m);
    chk(fl, fl_m);
  endtask : go

  // destination writes compared against the oldest note
  always @(posedge clk) begin
    if (rvld === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        chk(rdat, exp_q.pop_front());
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    #1;
    chk({rdy, ctrue, rvld, fl}, 8'h0);
    chk(pc | rdat, 32'h0);
    srst = 1'b0;
    @(posedge clk);
    #1;
    // alu flag setting, repeat, then a move for every code
    for (int i = 0; i < 48; i++) begin
      for (int j = 0; j < 2; j++) begin
        kind = CCB_OP_ALU;
        afl = $random(seed);
        amd = (j == 0) ? 10'h2aa : (i[0] ? $random(seed) : 10'h015);
        iss = 4'h1 + ($random(seed) & 3);
        rep = 4'h1 + ($random(seed) & 3);
        lat = 4'h1 + ($random(seed) & 3);
        wide = $random(seed);
        go();
      end
      kind = i[4] ? CCB_OP_CONDITIONAL_MOVE_IMM : CCB_OP_CONDITIONAL_MOVE_REG;
      cc = i[3:0];
      s1 = $random(seed);
      s2 = $random(seed);
      imm = $random(seed);
      go();
    end
    $display("test moves done");
    // branches on every code, taken and not
    for (int i = 0; i < 32; i++) begin
      kind = CCB_OP_ALU;
      afl = $random(seed);
      amd = 10'h2aa;
      go();
      kind = CCB_OP_BRANCH;
      cc = i[3:0];
      disp = $random(seed);
      go();
      go();
    end
    $display("test branches done");
    // byte swaps with zero bytes and halfwords among them
    cc = 4'h2;
    for (int i = 0; i < 16; i++) begin
      kind = i[0] ? CCB_OP_BSW : CCB_OP_BSH;
      s1 = (i < 4) ? (32'h0000ff80 << (i * 8)) : $random(seed);
      go();
    end
    $display("test swaps done");
    // status restore on both returns
    for (int i = 0; i < 8; i++) begin
      kind = i[0] ? CCB_OP_DBG_RET : CCB_OP_TC_RET;
      tcs = $random(seed);
      dbs = $random(seed);
      tcp = $random(seed);
      dbp = $random(seed);
      go();
    end
    $display("test returns done");
    chk(exp_q.size(), 0);
    wrap_up();
  end
endmodule : cpu_condition_and_branch_exec_tb
